/* File: flash_self_erase_write.sv */
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_self_erase_write import flash_seq_pkg::*; #(
  parameter int NUM_LATCHES = 32,
  parameter int BUSY_CYCLES = `FLASH_BUSY_NS / `FLASH_CLK_NS,
  parameter logic [13:0] DEV_ID = 14'h0123, // arbitrary value
  parameter logic [13:0] REV_ID = 14'h0001 // arbitrary value
) (
  input wire logic mclk, // 100 MHz system clock
  input wire logic resetn, // sync reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // unmapped address
  input wire logic [13:0] flash_rdata, // array word at flash_addr
  input wire logic [13:0] cfg_word1, // config word 1
  input wire logic [13:0] cfg_word2, // config word 2
  output logic cpu_nop, // force no-op
  output logic cpu_stall, // halt core
  output logic flash_erase, // row erase running
  output logic flash_prog, // row program running
  output logic [14:0] flash_addr, // word address
  output logic [NUM_LATCHES*14-1:0] flash_wdata // latch contents
);
  localparam int CW = $clog2(BUSY_CYCLES + 1);
  localparam int IW = $clog2(NUM_LATCHES);

  // apb slave state
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  // software-visible registers
  logic [7:0] addr_low_r, addr_low_nxt;
  logic [6:0] addr_high_r, addr_high_nxt;
  logic [7:0] data_low_r, data_low_nxt;
  logic [5:0] data_high_r, data_high_nxt;
  ctl_type ctl_r, ctl_nxt;
  key_state_type key_r, key_nxt;
  // sequencer state
  seq_state_type st_r, st_nxt;
  op_kind_type kind_r, kind_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic nop_r, nop_nxt;
  logic stall_r, stall_nxt;
  logic erase_r, erase_nxt;
  logic prog_r, prog_nxt;
  logic [13:0] uid_r [4];
  logic [13:0] uid_nxt [4];
  // combinational helpers
  logic acc, wr, hit_ctl, mapped, start, read_go, cfg_low, cfg_uid;
  logic clear_lat;
  logic cfg_sel_eff, cfg_ro, cfg_miss;
  logic [NUM_LATCHES-1:0] load_lat;
  logic [13:0] load_val, rd_val;
  logic [13:0] lat_q [NUM_LATCHES];
  op_kind_type req_kind;

  // access completes at the edge where pready is seen high
  assign acc = psel & penable & pready_r;
  assign wr = acc & pwrite;
  assign hit_ctl = (paddr == `OFS_CONTROL);
  assign mapped = (paddr == `OFS_ADDR_LOW) | (paddr == `OFS_ADDR_HIGH) | (paddr == `OFS_DATA_LOW) |
                  (paddr == `OFS_DATA_HIGH) | hit_ctl | (paddr == `OFS_UNLOCK);
  // a whole-word control write reads and loads in the space it selects, not the old one
  assign cfg_sel_eff = (wr && hit_ctl && st_r == st_idle) ? pwdata[`CTL_CFGSEL_BIT] : ctl_r.cfg_sel;
  // config region: high byte zero, low byte word index
  assign cfg_low = cfg_sel_eff & (addr_high_r == 7'h00);
  assign cfg_uid = cfg_low & (addr_low_r <= `CFG_UID_LAST);
  assign cfg_ro = cfg_low & (addr_low_r >= `CFG_REV_ID) & (addr_low_r <= `CFG_WORD2);
  assign cfg_miss = cfg_sel_eff & ~cfg_uid & ~cfg_ro;

  // operation kind from the control word being written
  always_comb begin
    if (pwdata[`CTL_ERASE_BIT]) begin
      req_kind = op_erase;
    end else if (pwdata[`CTL_LOADONLY_BIT]) begin
      req_kind = op_load;
    end else begin
      req_kind = op_program;
    end
  end

  // start needs armed keys, permit, idle; config rows cannot be erased
  assign start = wr & hit_ctl & pwdata[`CTL_START_BIT] & (key_r == key_armed)
               & pwdata[`CTL_PERMIT_BIT] & (st_r == st_idle)
               & ~(pwdata[`CTL_ERASE_BIT] & pwdata[`CTL_CFGSEL_BIT]);
  assign read_go = wr & hit_ctl & pwdata[`CTL_READ_BIT] & (st_r == st_idle);

  // read value: config map or array, zero outside permitted set
  always_comb begin
    rd_val = flash_rdata;
    if (cfg_sel_eff) begin
      rd_val = 14'h0000;
      if (cfg_uid) begin
        rd_val = uid_r[addr_low_r[1:0]];
      end else if (cfg_low && addr_low_r == `CFG_REV_ID) begin
        rd_val = REV_ID;
      end else if (cfg_low && addr_low_r == `CFG_DEV_ID) begin
        rd_val = DEV_ID;
      end else if (cfg_low && addr_low_r == `CFG_WORD1) begin
        rd_val = cfg_word1;
      end else if (cfg_low && addr_low_r == `CFG_WORD2) begin
        rd_val = cfg_word2;
      end
    end
  end

  // apb answer: one wait cycle, data prepared with ready
  always_comb begin
    pready_nxt = psel & penable & ~pready_r;
    pslverr_nxt = psel & penable & ~pready_r & ~mapped;
    prdata_nxt = 32'h0000_0000;
    if (psel && penable && !pready_r && !pwrite) begin
      unique case (paddr)
        `OFS_ADDR_LOW: prdata_nxt = {24'h00_0000, addr_low_r};
        `OFS_ADDR_HIGH: prdata_nxt = {25'h000_0000, addr_high_r};
        `OFS_DATA_LOW: prdata_nxt = {24'h00_0000, data_low_r};
        `OFS_DATA_HIGH: prdata_nxt = {26'h000_0000, data_high_r};
        `OFS_CONTROL: prdata_nxt = {24'h00_0000, st_r != st_idle, ctl_r.cfg_sel, ctl_r.load_only,
                                    ctl_r.row_erase, 1'b0, ctl_r.permit, ctl_r.start, 1'b0};
        default: prdata_nxt = 32'h0000_0000; // unlock port reads zero
      endcase
    end
  end

  // unlock keys: any other write breaks the sequence
  always_comb begin
    key_nxt = key_r;
    if (wr) begin
      key_nxt = key_idle;
      if (paddr == `OFS_UNLOCK) begin
        if (pwdata[7:0] == `KEY_FIRST) begin
          key_nxt = key_half;
        end else if (pwdata[7:0] == `KEY_SECOND && key_r == key_half) begin
          key_nxt = key_armed;
        end
      end
    end
  end

  // address, data and control registers
  always_comb begin
    addr_low_nxt = addr_low_r;
    addr_high_nxt = addr_high_r;
    data_low_nxt = data_low_r;
    data_high_nxt = data_high_r;
    ctl_nxt = ctl_r;
    if (wr && paddr == `OFS_ADDR_LOW) begin
      addr_low_nxt = pwdata[7:0];
    end
    if (wr && paddr == `OFS_ADDR_HIGH) begin
      addr_high_nxt = pwdata[6:0];
    end
    if (wr && paddr == `OFS_DATA_LOW) begin
      data_low_nxt = pwdata[7:0];
    end
    if (wr && paddr == `OFS_DATA_HIGH) begin
      data_high_nxt = pwdata[5:0];
    end
    // control frozen while an operation runs
    if (wr && hit_ctl && st_r == st_idle) begin
      ctl_nxt.cfg_sel = pwdata[`CTL_CFGSEL_BIT];
      ctl_nxt.load_only = pwdata[`CTL_LOADONLY_BIT];
      ctl_nxt.row_erase = pwdata[`CTL_ERASE_BIT];
      ctl_nxt.permit = pwdata[`CTL_PERMIT_BIT];
      ctl_nxt.start = start;
    end
    if (st_r == st_finish) begin
      ctl_nxt.start = 1'b0;
    end
    if (read_go) begin
      data_low_nxt = rd_val[7:0];
      data_high_nxt = rd_val[13:8];
    end
  end

  // latch load at start; read-only config words never loaded
  assign load_val = {data_high_r, data_low_r};
  always_comb begin
    load_lat = '0;
    if (start && req_kind != op_erase && (!pwdata[`CTL_CFGSEL_BIT] || cfg_uid)) begin
      load_lat[addr_low_r[IW-1:0]] = 1'b1;
    end
  end
  assign clear_lat = (st_r == st_finish) && (kind_r != op_load);

  // sequencer: two no-op cycles, then stall for erase and program
  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      st_idle: begin
        if (start) begin
          st_nxt = st_setup;
          kind_nxt = req_kind;
          cnt_nxt = '0;
        end
      end
      st_setup: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CW'(`SETUP_CYCLES - 1)) begin
          cnt_nxt = '0;
          st_nxt = (kind_r == op_load) ? st_finish : st_busy;
        end
      end
      st_busy: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CW'(BUSY_CYCLES - 1)) begin
          st_nxt = st_finish;
        end
      end
      st_finish: begin
        st_nxt = st_idle;
      end
    endcase
  end

  // core and array controls follow the next state
  always_comb begin
    nop_nxt = (st_nxt == st_setup);
    stall_nxt = (st_nxt == st_busy);
    erase_nxt = (st_nxt == st_busy) && (kind_nxt == op_erase);
    // no implicit erase before programming
    prog_nxt = (st_nxt == st_busy) && (kind_nxt == op_program) && !ctl_r.cfg_sel;
  end

  // user IDs take latches 0..3 when a config program finishes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      uid_nxt[i] = uid_r[i];
      if (st_r == st_finish && kind_r == op_program && ctl_r.cfg_sel) begin
        uid_nxt[i] = lat_q[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      addr_low_r <= 8'h00;
      addr_high_r <= 7'h00;
      data_low_r <= 8'h00;
      data_high_r <= 6'h00;
      ctl_r <= '0;
      key_r <= key_idle;
      st_r <= st_idle;
      kind_r <= op_load;
      cnt_r <= '0;
      nop_r <= 1'b0;
      stall_r <= 1'b0;
      erase_r <= 1'b0;
      prog_r <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        uid_r[i] <= `LATCH_BLANK;
      end
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      addr_low_r <= addr_low_nxt;
      addr_high_r <= addr_high_nxt;
      data_low_r <= data_low_nxt;
      data_high_r <= data_high_nxt;
      ctl_r <= ctl_nxt;
      key_r <= key_nxt;
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      nop_r <= nop_nxt;
      stall_r <= stall_nxt;
      erase_r <= erase_nxt;
      prog_r <= prog_nxt;
      uid_r <= uid_nxt;
    end
  end

  // one latch word per row slot
  for (genvar g = 0; g < NUM_LATCHES; g++) begin : g_lat
    flash_latch_word #(.W(14), .BLANK(`LATCH_BLANK)) u_word (
      .mclk(mclk),
      .resetn(resetn),
      .clear(clear_lat),
      .load(load_lat[g]),
      .din(load_val),
      .q(lat_q[g])
    );
    assign flash_wdata[g*14 +: 14] = lat_q[g];
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cpu_nop = nop_r;
  assign cpu_stall = stall_r;
  assign flash_erase = erase_r;
  assign flash_prog = prog_r;
  assign flash_addr = {addr_high_r, addr_low_r};

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_nops;
    nop_r [*2] ##1 !nop_r;
  endsequence

  a_nop_pair: assert property ($rose(ctl_r.start) |-> s_nops)
    else $error("start not followed by exactly two no-op cycles");
  a_start_keyed: assert property ($rose(ctl_r.start) |-> $past(key_r) == key_armed)
    else $error("operation started without unlock keys");
  a_start_permit: assert property ($rose(ctl_r.start) |-> ctl_r.permit)
    else $error("operation started without write permit");
  a_start_hold: assert property ($fell(ctl_r.start) |-> $past(st_r) == st_finish)
    else $error("op start cleared before completion");
  a_stall_after: assert property ($fell(nop_r) && kind_r != op_load |-> stall_r)
    else $error("stall missing after no-ops");
  a_load_free: assert property (kind_r == op_load |-> !stall_r && !flash_prog)
    else $error("latch load stalled or programmed");
  a_blank_after: assert property (st_r == st_finish && kind_r != op_load |=> lat_q[0] == `LATCH_BLANK)
    else $error("latches not blank after operation");
  a_ro_kept: assert property (load_lat != '0 && pwdata[`CTL_CFGSEL_BIT] |-> cfg_uid)
    else $error("read-only config word loaded");
  a_bad_cfg_zero: assert property (read_go && cfg_miss |=> {data_high_r, data_low_r} == 14'h0)
    else $error("bad config read did not clear data");

  // array and core strobes stay consistent with the sequencer
  a_erase_stall: assert property (flash_erase |-> cpu_stall && !flash_prog)
    else $error("erase running without core stall");
  a_stall_end: assert property ($fell(stall_r) |-> st_r == st_finish)
    else $error("stall ended before the operation finished");
  a_cfg_no_prog: assert property (flash_prog |-> !ctl_r.cfg_sel)
    else $error("array programmed while config space selected");
  a_nop_no_stall: assert property (nop_r |-> !stall_r)
    else $error("core stalled during forced no-ops");
endmodule : flash_self_erase_write

/* File: flash_seq_regs.svh */
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// register byte offsets
`define OFS_ADDR_LOW 8'h00
`define OFS_ADDR_HIGH 8'h04
`define OFS_DATA_LOW 8'h08
`define OFS_DATA_HIGH 8'h0c
`define OFS_CONTROL 8'h10
`define OFS_UNLOCK 8'h14
// control field positions
`define CTL_READ_BIT 0
`define CTL_START_BIT 1
`define CTL_PERMIT_BIT 2
`define CTL_ERASE_BIT 4
`define CTL_LOADONLY_BIT 5
`define CTL_CFGSEL_BIT 6
`define CTL_BUSY_BIT 7
// unlock keys and blank word
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define LATCH_BLANK 14'h3fff
// config space word indices
`define CFG_UID_LAST 8'h03
`define CFG_REV_ID 8'h05
`define CFG_DEV_ID 8'h06
`define CFG_WORD1 8'h07
`define CFG_WORD2 8'h08
// timing
`define FLASH_CLK_NS 10
`define FLASH_BUSY_NS 2000000
`define SETUP_CYCLES 2
`endif

/* File: flash_seq_pkg.sv */
package flash_seq_pkg;
  typedef enum logic [1:0] {st_idle, st_setup, st_busy, st_finish} seq_state_type;
  typedef enum logic [1:0] {op_load, op_program, op_erase} op_kind_type;
  typedef enum logic [1:0] {key_idle, key_half, key_armed} key_state_type;
  typedef struct packed {
    logic cfg_sel;
    logic load_only;
    logic row_erase;
    logic permit;
    logic start;
  } ctl_type;
endpackage : flash_seq_pkg

/* File: flash_latch_word.sv */
`timescale 1ns/1ps
// one write latch word, blank after reset or clear
module flash_latch_word #(
  parameter int W = 14,
  parameter logic [13:0] BLANK = 14'h3fff
) (
  input wire logic mclk, // system clock
  input wire logic resetn, // sync reset, low
  input wire logic clear, // back to blank
  input wire logic load, // take din
  input wire logic [W-1:0] din, // word to hold
  output logic [W-1:0] q // held word
);
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // clear has priority; load and clear never meet
  always_comb begin
    q_nxt = q_r;
    if (clear) begin
      q_nxt = BLANK[W-1:0];
    end else if (load) begin
      q_nxt = din;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      q_r <= BLANK[W-1:0];
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : flash_latch_word

/* File: flash_array_model.sv */
`timescale 1ns/1ps
// behavioural flash array on the far side of the sequencer
module flash_array_model (
  input wire logic mclk, // system clock
  input wire logic flash_erase, // row erase running
  input wire logic flash_prog, // row program running
  input wire logic [14:0] flash_addr, // word address
  input wire logic [447:0] flash_wdata, // latch contents
  output logic [13:0] flash_rdata // word at flash_addr
);
  logic [13:0] mem [0:32767];
  // array starts blank, like a fresh part
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 14'h3fff;
    end
  end
  // programming can only clear bits, so a missing erase shows up on readback
  always @(posedge mclk) begin
    for (int g = 0; g < 32; g++) begin
      if (flash_erase === 1'b1) begin
        mem[{flash_addr[14:5], 5'(g)}] <= 14'h3fff;
      end else if (flash_prog === 1'b1) begin
        mem[{flash_addr[14:5], 5'(g)}] <= mem[{flash_addr[14:5], 5'(g)}] & flash_wdata[g*14 +: 14];
      end
    end
  end
  assign flash_rdata = mem[flash_addr];
endmodule : flash_array_model

/* File: flash_self_erase_write_tb.sv */
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module flash_self_erase_write_tb import flash_seq_pkg::*;;
  localparam int BUSY = 20;
  localparam logic [13:0] REV = 14'h0a5c; // arbitrary value
  localparam logic [13:0] DEV = 14'h0b17; // arbitrary value
  localparam logic [13:0] CW1 = 14'h2c3d;
  localparam logic [13:0] CW2 = 14'h1e4f;
  logic mclk = 1'b0;
  logic resetn, psel, penable, pwrite, pready, pslverr, cpu_nop, cpu_stall, flash_erase, flash_prog, errv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [13:0] flash_rdata, w;
  logic [14:0] flash_addr;
  logic [447:0] flash_wdata;
  int n_fail, total_checks, nop_cnt, stall_cnt, prog_cnt, er_cnt;
  always #5 mclk = ~mclk;
  flash_self_erase_write #(.BUSY_CYCLES(BUSY), .DEV_ID(DEV), .REV_ID(REV)) DUT (.mclk(mclk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_rdata(flash_rdata), .cfg_word1(CW1), .cfg_word2(CW2),
    .cpu_nop(cpu_nop), .cpu_stall(cpu_stall), .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata));
  flash_array_model FLASH (.mclk(mclk), .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata));
  // cycle counts of the core and array strobes, cleared before each start
  always @(posedge mclk) begin
    if (cpu_nop === 1'b1) nop_cnt++;
    if (cpu_stall === 1'b1) stall_cnt++;
    if (flash_prog === 1'b1) prog_cnt++;
    if (flash_erase === 1'b1) er_cnt++;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  // one apb transfer; an idle edge after it so psel is never set twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    `CHK("pready", 1'b1, pready)
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task set_ad(input logic [14:0] a, input logic [13:0] d);
    apb(1, `OFS_ADDR_LOW, {24'h0, a[7:0]});
    apb(1, `OFS_ADDR_HIGH, {25'h0, a[14:8]});
    apb(1, `OFS_DATA_LOW, {24'h0, d[7:0]});
    apb(1, `OFS_DATA_HIGH, {26'h0, d[13:8]});
  endtask : set_ad
  task keys;
    apb(1, `OFS_UNLOCK, 32'h55);
    apb(1, `OFS_UNLOCK, 32'haa);
  endtask : keys
  // start with a clean count, wait for busy to drop, then op_start must read clear
  task automatic run_op(input logic [31:0] ctl);
    int n;
    n = 0;
    nop_cnt = 0; stall_cnt = 0; prog_cnt = 0; er_cnt = 0;
    apb(1, `OFS_CONTROL, ctl);
    do begin
      apb(0, `OFS_CONTROL, 32'h0);
      n++;
    end while (rdv[7] !== 1'b0 && n < 100);
    apb(0, `OFS_CONTROL, 32'h0);
    `CHK("busy", 1'b0, rdv[7])
    `CHK("op_start", 1'b0, rdv[1])
  endtask : run_op
  task rd_word(input logic [14:0] a, input logic cfg);
    set_ad(a, 14'h0);
    apb(1, `OFS_CONTROL, cfg ? 32'h41 : 32'h01);
    apb(0, `OFS_DATA_LOW, 32'h0);
    w[7:0] = rdv[7:0];
    apb(0, `OFS_DATA_HIGH, 32'h0);
    w[13:8] = rdv[5:0];
  endtask : rd_word
  task t_reset;
    `CHK("latches", {32{14'h3fff}}, flash_wdata)
    apb(0, `OFS_CONTROL, 32'h0);
    `CHK("control", 32'h0, rdv)
    apb(0, `OFS_UNLOCK, 32'h0);
    `CHK("key read", 32'h0, rdv)
    apb(0, 8'h18, 32'h0);
    `CHK("slverr", 1'b1, errv)
    $display("test reset done");
  endtask : t_reset
  // broken or misplaced keys, and missing permit, start nothing
  task t_unlock;
    set_ad(15'h0100, 14'h0777);
    apb(1, `OFS_UNLOCK, 32'h55);
    apb(1, `OFS_DATA_LOW, 32'h77);
    apb(1, `OFS_UNLOCK, 32'haa);
    run_op(32'h26);
    `CHK("nop split", 0, nop_cnt)
    keys();
    apb(1, `OFS_DATA_LOW, 32'h77);
    run_op(32'h26);
    `CHK("nop late", 0, nop_cnt)
    keys();
    run_op(32'h22);
    `CHK("nop permit", 0, nop_cnt)
    `CHK("latch 0", 14'h3fff, flash_wdata[13:0])
    $display("test unlock done");
  endtask : t_unlock
  task t_flash;
    set_ad(15'h1460, 14'h1abc);
    keys();
    run_op(32'h26);
    `CHK("load nop", 2, nop_cnt)
    `CHK("load stall", 0, stall_cnt)
    `CHK("load prog", 0, prog_cnt)
    `CHK("latch 0", 14'h1abc, flash_wdata[13:0])
    set_ad(15'h147f, 14'h0155);
    keys();
    run_op(32'h06);
    `CHK("prog nop", 2, nop_cnt)
    `CHK("prog stall", BUSY, stall_cnt)
    `CHK("prog len", BUSY, prog_cnt)
    `CHK("latches", {32{14'h3fff}}, flash_wdata)
    rd_word(15'h1460, 1'b0);
    `CHK("word 0", 14'h1abc, w)
    rd_word(15'h147f, 1'b0);
    `CHK("word 31", 14'h0155, w)
    rd_word(15'h1461, 1'b0);
    `CHK("word 1", 14'h3fff, w)
    rd_word(15'h1480, 1'b0);
    `CHK("next row", 14'h3fff, w)
    set_ad(15'h1475, 14'h0);
    keys();
    run_op(32'h16);
    `CHK("erase len", BUSY, er_cnt)
    `CHK("erase stall", BUSY, stall_cnt)
    `CHK("erase nop", 2, nop_cnt)
    rd_word(15'h1460, 1'b0);
    `CHK("erased 0", 14'h3fff, w)
    rd_word(15'h147f, 1'b0);
    `CHK("erased 31", 14'h3fff, w)
    $display("test flash done");
  endtask : t_flash
  // overwrite without erase, then the read, erase and reload path
  task t_modify;
    logic [13:0] keep;
    set_ad(15'h1465, 14'h0a0a);
    keys();
    run_op(32'h06);
    rd_word(15'h1465, 1'b0);
    keep = w;
    `CHK("word 5", 14'h0a0a, w)
    set_ad(15'h1465, 14'h1555);
    keys();
    run_op(32'h06);
    rd_word(15'h1465, 1'b0);
    `CHK("no erase", 14'h0000, w)
    set_ad(15'h1460, 14'h0);
    keys();
    run_op(32'h16);
    set_ad(15'h1465, keep);
    keys();
    run_op(32'h26);
    set_ad(15'h1466, 14'h0b0b);
    keys();
    run_op(32'h06);
    rd_word(15'h1465, 1'b0);
    `CHK("kept word", 14'h0a0a, w)
    rd_word(15'h1466, 1'b0);
    `CHK("new word", 14'h0b0b, w)
    $display("test modify done");
  endtask : t_modify
  task t_config;
    set_ad(15'h0002, 14'h1234);
    keys();
    run_op(32'h66);
    set_ad(15'h0005, 14'h0abc);
    keys();
    run_op(32'h46);
    `CHK("cfg prog", 0, prog_cnt)
    keys();
    run_op(32'h56);
    `CHK("cfg erase", 0, nop_cnt)
    rd_word(15'h0002, 1'b1);
    `CHK("uid 2", 14'h1234, w)
    rd_word(15'h0002, 1'b0);
    `CHK("array 2", 14'h3fff, w)
    rd_word(15'h0005, 1'b1);
    `CHK("rev", REV, w)
    rd_word(15'h0006, 1'b1);
    `CHK("dev", DEV, w)
    rd_word(15'h0007, 1'b1);
    `CHK("cfg1", CW1, w)
    rd_word(15'h0008, 1'b1);
    `CHK("cfg2", CW2, w)
    rd_word(15'h0004, 1'b1);
    `CHK("hole", 14'h0, w)
    rd_word(15'h0009, 1'b1);
    `CHK("beyond", 14'h0, w)
    $display("test config done");
  endtask : t_config
  // reset in mid-run drops loaded latches, armed keys and permit
  task t_rereset;
    set_ad(15'h0205, 14'h0123);
    keys();
    run_op(32'h26);
    `CHK("latch 5", 14'h0123, flash_wdata[5*14 +: 14])
    keys();
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    `CHK("reset latches", {32{14'h3fff}}, flash_wdata)
    apb(0, `OFS_CONTROL, 32'h0);
    `CHK("reset permit", 1'b0, rdv[2])
    run_op(32'h26);
    `CHK("reset keys", 0, nop_cnt)
    $display("test reset again done");
  endtask : t_rereset
  // hang guard, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    stop_test();
  end
  initial begin
    resetn <= 1'b0; psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0; paddr <= 8'h00; pwdata <= 32'h0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_unlock();
    t_flash();
    t_modify();
    t_config();
    t_rereset();
    stop_test();
  end
endmodule : flash_self_erase_write_tb
